// file: logic/bfto_pkg.sv
// Shared constants, types and helpers for the binning / format / tap output block.
// Assumes a 125 MHz system clock and a separate Camera Link pixel clock.
`default_nettype none

package bfto_pkg;

    // Register map, byte addresses on the plain register port
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam logic [7:0]  REG_ENGINE   = 8'h00;
    localparam logic [7:0]  REG_BIN      = 8'h04;
    localparam logic [7:0]  REG_FMT      = 8'h08;
    localparam logic [7:0]  REG_LAYOUT   = 8'h0c;
    localparam logic [7:0]  REG_RATE     = 8'h10;
    localparam logic [7:0]  REG_RATE_MHZ = 8'h14;
    localparam logic [7:0]  REG_STATUS   = 8'h18;

    // Field positions
    localparam int BIN_VF_LSB    = 0;
    localparam int BIN_VM_BIT    = 4;
    localparam int BIN_HF_LSB    = 8;
    localparam int BIN_HM_BIT    = 12;
    localparam int FMT_BAYER_BIT = 2;
    localparam int STS_BUSY_BIT  = 0;
    localparam int STS_REFUSED_BIT = 1;

    // Sample and datapath widths
    localparam int          SAMPLE_W  = 12;
    localparam int          ACC_W     = 16;
    localparam int          MAX_TAPS  = 10;
    localparam logic [11:0] SAMPLE_MAX = 12'hfff;

    // Pixel clock readback values in MHz
    localparam logic [7:0] RATE0_MHZ = 8'h55;
    localparam logic [7:0] RATE1_MHZ = 8'h41;

    typedef enum logic { BFTO_SENSOR, BFTO_LOGIC } bfto_engine_t;
    typedef enum logic { BFTO_AVG, BFTO_SUM } bfto_method_t;
    typedef enum logic [1:0] { BFTO_W8, BFTO_W10, BFTO_W12 } bfto_width_t;
    typedef enum logic [1:0] { BFTO_T2, BFTO_T4, BFTO_T8, BFTO_T10 } bfto_layout_t;

    typedef struct packed {
        bfto_method_t hm;
        logic [2:0]   hf;
        bfto_method_t vm;
        logic [2:0]   vf;
    } bfto_bin_cfg_t;

    typedef struct packed {
        logic        sof;
        logic        sol;
        logic        eol;
        logic [11:0] data;
    } bfto_pix_t;

    typedef struct packed {
        logic                      sof;
        logic                      eol;
        logic [3:0]                count;
        logic [MAX_TAPS-1:0][11:0] taps;
    } bfto_word_t;

    // Reset values
    localparam bfto_bin_cfg_t BIN_CFG_RST = '{hm: BFTO_AVG, hf: 3'h1, vm: BFTO_AVG, vf: 3'h1};
    localparam bfto_engine_t  ENGINE_RST  = BFTO_SENSOR;
    localparam bfto_width_t   WIDTH_RST   = BFTO_W12;
    localparam bfto_layout_t  LAYOUT_RST  = BFTO_T2;

    // Taps per pixel clock for a lane layout
    function automatic logic [3:0] bfto_taps(input bfto_layout_t l);
        case (l)
            BFTO_T2: bfto_taps = 4'h2;
            BFTO_T4: bfto_taps = 4'h4;
            BFTO_T8: bfto_taps = 4'h8;
            default: bfto_taps = 4'ha;
        endcase
    endfunction

    // Shift for a logic factor of 1, 2 or 4
    function automatic logic [2:0] bfto_lg2(input logic [2:0] f);
        bfto_lg2 = (f == 3'h4) ? 3'h2 : ((f == 3'h2) ? 3'h1 : 3'h0);
    endfunction

    // Low bits discarded for an output width
    function automatic logic [2:0] bfto_drop(input bfto_width_t w);
        case (w)
            BFTO_W8:  bfto_drop = 3'h4;
            BFTO_W10: bfto_drop = 3'h2;
            default:  bfto_drop = 3'h0;
        endcase
    endfunction

endpackage : bfto_pkg

`default_nettype wire

// file: logic/bfto_top.sv
// Binning, sample width reduction and interleaved tap output toward a frame grabber.
// Assumes pixels arrive on clk from same-clock logic and link_clk runs the pixel clock.
`default_nettype none

module bfto_top
    import bfto_pkg::*;
#(
    parameter int   MAX_LINE     = 2048,
    parameter logic COLOR_SENSOR = 1'b0
) (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic [ADDR_W-1:0]         reg_addr,
    input  wire logic [DATA_W-1:0]         reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output var  logic [DATA_W-1:0]         reg_rdata,
    input  wire logic                      pix_in_valid,
    input  wire bfto_pix_t                 pix_in,
    output var  logic                      pix_in_ready,
    output var  logic [2:0]                sensor_bin_factor,
    output var  bfto_method_t              sensor_bin_method,
    output var  logic                      link_rate_select,
    input  wire logic                      link_clk,
    output var  logic [MAX_TAPS-1:0][11:0] cl_taps,
    output var  logic [3:0]                cl_count,
    output var  logic                      cl_dval,
    output var  logic                      cl_sof,
    output var  logic                      cl_eol
);

    localparam int COL_W = $clog2(MAX_LINE);

    // Reset release, two stages per domain
    logic rst_q1, rst_q2, lrst_q1, lrst_q2;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            lrst_q1 <= 1'b0;
            lrst_q2 <= 1'b0;
        end else begin
            lrst_q1 <= 1'b1;
            lrst_q2 <= lrst_q1;
        end
    end

    // ---------------- Register file ----------------
    bfto_engine_t  engine, next_engine;
    bfto_bin_cfg_t sens_cfg, next_sens_cfg, logic_cfg, next_logic_cfg;
    bfto_width_t   width, next_width;
    logic          bayer, next_bayer;
    bfto_layout_t  layout, next_layout;
    logic          rate, next_rate;
    logic [7:0]    rate_mhz, next_rate_mhz;
    logic          refused, next_refused;
    logic [31:0]   next_rdata;
    logic          busy;
    bfto_bin_cfg_t wcfg;

    // Decode writes, refusing illegal combinations whole
    always_comb begin
        next_engine    = engine;
        next_sens_cfg  = sens_cfg;
        next_logic_cfg = logic_cfg;
        next_width     = width;
        next_bayer     = bayer;
        next_layout    = layout;
        next_rate      = rate;
        next_refused   = refused;
        wcfg.hm        = bfto_method_t'(reg_wdata[BIN_HM_BIT]);
        wcfg.hf        = reg_wdata[BIN_HF_LSB +: 3];
        wcfg.vm        = bfto_method_t'(reg_wdata[BIN_VM_BIT]);
        wcfg.vf        = reg_wdata[BIN_VF_LSB +: 3];
        if (reg_wr) begin
            next_refused = 1'b0;
            case (reg_addr)
                REG_ENGINE: next_engine = bfto_engine_t'(reg_wdata[0]);
                REG_BIN: begin
                    if (engine == BFTO_SENSOR) begin
                        // Sensor: average only, horizontal mirrors vertical
                        if (wcfg.vm == BFTO_AVG && wcfg.vf >= 3'h1 && wcfg.vf <= 3'h3) begin
                            next_sens_cfg = '{hm: BFTO_AVG, hf: wcfg.vf, vm: BFTO_AVG, vf: wcfg.vf};
                        end else begin
                            next_refused = 1'b1;
                        end
                    end else begin
                        if ((wcfg.hf == 3'h1 || wcfg.hf == 3'h2 || wcfg.hf == 3'h4) &&
                            (wcfg.vf == 3'h1 || wcfg.vf == 3'h2 || wcfg.vf == 3'h4)) begin
                            next_logic_cfg = wcfg;
                        end else begin
                            next_refused = 1'b1;
                        end
                    end
                end
                REG_FMT: begin
                    // Mono sensor has no 8-bit or Bayer formats
                    if (reg_wdata[1:0] != 2'h3 &&
                        (COLOR_SENSOR || (reg_wdata[1:0] != 2'h0 && !reg_wdata[FMT_BAYER_BIT]))) begin
                        next_width = bfto_width_t'(reg_wdata[1:0]);
                        next_bayer = reg_wdata[FMT_BAYER_BIT];
                    end else begin
                        next_refused = 1'b1;
                    end
                end
                REG_LAYOUT: next_layout = bfto_layout_t'(reg_wdata[1:0]);
                REG_RATE:   next_rate = reg_wdata[0];
                default:    next_refused = refused;
            endcase
        end
        next_rate_mhz = next_rate ? RATE1_MHZ : RATE0_MHZ;
    end

    // Read data valid only in the cycle after the strobe
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                REG_ENGINE: next_rdata = {31'h0, engine};
                REG_BIN: begin
                    next_rdata[BIN_VF_LSB +: 3] = (engine == BFTO_SENSOR) ? sens_cfg.vf : logic_cfg.vf;
                    next_rdata[BIN_VM_BIT]      = (engine == BFTO_SENSOR) ? sens_cfg.vm : logic_cfg.vm;
                    next_rdata[BIN_HF_LSB +: 3] = (engine == BFTO_SENSOR) ? sens_cfg.hf : logic_cfg.hf;
                    next_rdata[BIN_HM_BIT]      = (engine == BFTO_SENSOR) ? sens_cfg.hm : logic_cfg.hm;
                end
                REG_FMT:      next_rdata = {29'h0, bayer, width};
                REG_LAYOUT:   next_rdata = {30'h0, layout};
                REG_RATE:     next_rdata = {31'h0, rate};
                REG_RATE_MHZ: next_rdata = {24'h0, rate_mhz};
                REG_STATUS:   next_rdata = {30'h0, refused, busy};
                default:      next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_q2) begin
        if (!rst_q2) begin
            engine            <= ENGINE_RST;
            sens_cfg          <= BIN_CFG_RST;
            logic_cfg         <= BIN_CFG_RST;
            width             <= WIDTH_RST;
            bayer             <= 1'b0;
            layout            <= LAYOUT_RST;
            rate              <= 1'b0;
            rate_mhz          <= RATE0_MHZ;
            refused           <= 1'b0;
            reg_rdata         <= 32'h0000_0000;
            sensor_bin_factor <= 3'h1;
            sensor_bin_method <= BFTO_AVG;
            link_rate_select  <= 1'b0;
        end else begin
            engine            <= next_engine;
            sens_cfg          <= next_sens_cfg;
            logic_cfg         <= next_logic_cfg;
            width             <= next_width;
            bayer             <= next_bayer;
            layout            <= next_layout;
            rate              <= next_rate;
            rate_mhz          <= next_rate_mhz;
            refused           <= next_refused;
            reg_rdata         <= next_rdata;
            sensor_bin_factor <= next_sens_cfg.vf;
            sensor_bin_method <= next_sens_cfg.vm;
            link_rate_select  <= next_rate;
        end
    end

    // ---------------- Binning datapath ----------------
    bfto_bin_cfg_t act_cfg, next_act_cfg, cfg;
    bfto_width_t   act_width, next_act_width, wsel;
    bfto_layout_t  act_layout, next_act_layout;
    logic [2:0]    hcnt, next_hcnt, vrow, next_vrow;
    logic [ACC_W-1:0] hsum, next_hsum, acc, vt;
    logic [COL_W-1:0] col, next_col;
    logic [ACC_W-1:0] lbuf [MAX_LINE];
    logic          lbuf_we;
    logic          take, hdone, out_stb, out_eol, first, next_first;
    logic [11:0]   res, outv;
    logic [3:0]    ntaps, tidx, next_tidx;
    bfto_word_t    word, next_word;
    logic          req_tgl, next_req_tgl, ack_s1, ack_s2, next_ready, lk_ack_tgl;

    assign take = pix_in_valid && pix_in_ready;
    assign busy = req_tgl ^ ack_s2;

    // Settings apply from the first pixel of a frame onward
    always_comb begin
        next_act_cfg    = act_cfg;
        next_act_width  = act_width;
        next_act_layout = act_layout;
        if (take && pix_in.sof) begin
            next_act_cfg    = logic_cfg;
            next_act_width  = width;
            next_act_layout = layout;
        end
        cfg   = next_act_cfg;
        wsel  = next_act_width;
        ntaps = bfto_taps(next_act_layout);
    end

    // Horizontal then vertical accumulation, finish, width cut, tap packing
    always_comb begin
        next_hcnt    = hcnt;
        next_hsum    = hsum;
        next_col     = col;
        next_vrow    = vrow;
        next_first   = first;
        next_tidx    = tidx;
        next_word    = word;
        next_req_tgl = req_tgl;
        lbuf_we      = 1'b0;
        out_stb      = 1'b0;
        out_eol      = 1'b0;
        res          = 12'h000;
        // 12-bit sample widened for the group sum
        acc   = ((hcnt == 3'h0 || pix_in.sol) ? 16'h0000 : hsum) + {4'h0, pix_in.data};
        hdone = (hcnt == cfg.hf - 3'h1) || pix_in.eol;
        vt    = ((vrow == 3'h0 || pix_in.sof) ? 16'h0000 : lbuf[col]) + acc;
        if (take) begin
            if (pix_in.sof) begin
                next_first = 1'b1;
                next_vrow  = 3'h0;
            end
            next_hsum = acc;
            next_hcnt = hdone ? 3'h0 : hcnt + 3'h1;
            if (pix_in.sol) begin
                next_col = '0;
            end
            if (hdone) begin
                next_col = (pix_in.eol) ? '0 : ((pix_in.sol ? '0 : col) + COL_W'(1));
                if ((pix_in.sof ? 3'h0 : vrow) == cfg.vf - 3'h1) begin
                    out_stb = 1'b1;
                    out_eol = pix_in.eol;
                end else begin
                    lbuf_we = 1'b1;
                end
            end
            if (pix_in.eol) begin
                next_vrow = ((pix_in.sof ? 3'h0 : vrow) == cfg.vf - 3'h1) ? 3'h0 :
                            (pix_in.sof ? 3'h1 : vrow + 3'h1);
            end
        end
        // Sum clips at the top code; average drops the remainder
        if (cfg.hm == BFTO_SUM) begin
            res = (vt > {4'h0, SAMPLE_MAX}) ? SAMPLE_MAX : vt[11:0];
        end else begin
            res = 12'(vt >> (bfto_lg2(cfg.hf) + bfto_lg2(cfg.vf)));
        end
        outv = res >> bfto_drop(wsel);
        if (out_stb) begin
            if (tidx == 4'h0) begin
                next_word = '0; // Pad unused lanes of a short word
            end
            next_word.taps[tidx] = outv;
            next_word.count      = tidx + 4'h1;
            // Next value, so a frame-start pixel that closes a group is marked too
            if (next_first) begin
                next_word.sof = 1'b1;
                next_first    = 1'b0;
            end
            next_word.eol = out_eol;
            // Consecutive pixels fill lanes in turn rather than per-lane segments
            if (tidx == ntaps - 4'h1 || out_eol) begin
                next_tidx    = 4'h0;
                next_req_tgl = ~req_tgl;
            end else begin
                next_tidx = tidx + 4'h1;
            end
        end
        // Hold the source while a word waits to cross
        next_ready = !(next_req_tgl ^ ack_s2);
    end

    // Line buffer holds partial vertical sums per output column
    always_ff @(posedge clk) begin
        if (lbuf_we) begin
            lbuf[col] <= vt;
        end
    end

    always_ff @(posedge clk or negedge rst_q2) begin
        if (!rst_q2) begin
            act_cfg      <= BIN_CFG_RST;
            act_width    <= WIDTH_RST;
            act_layout   <= LAYOUT_RST;
            hcnt         <= 3'h0;
            hsum         <= 16'h0000;
            col          <= '0;
            vrow         <= 3'h0;
            first        <= 1'b0;
            tidx         <= 4'h0;
            word         <= '0;
            req_tgl      <= 1'b0;
            ack_s1       <= 1'b0;
            ack_s2       <= 1'b0;
            pix_in_ready <= 1'b0;
        end else begin
            act_cfg      <= next_act_cfg;
            act_width    <= next_act_width;
            act_layout   <= next_act_layout;
            hcnt         <= next_hcnt;
            hsum         <= next_hsum;
            col          <= next_col;
            vrow         <= next_vrow;
            first        <= next_first;
            tidx         <= next_tidx;
            word         <= next_word;
            req_tgl      <= next_req_tgl;
            ack_s1       <= lk_ack_tgl;
            ack_s2       <= ack_s1;
            pix_in_ready <= next_ready;
        end
    end

    // ---------------- Link domain ----------------
    // Toggle handshake; word stays frozen on clk side until acknowledged
    logic lk_req_s1, lk_req_s2, next_lk_ack_tgl;
    logic [MAX_TAPS-1:0][11:0] next_cl_taps;
    logic [3:0] next_cl_count;
    logic next_cl_dval, next_cl_sof, next_cl_eol;

    always_comb begin
        next_lk_ack_tgl = lk_ack_tgl;
        next_cl_taps    = cl_taps;
        next_cl_count   = cl_count;
        next_cl_dval    = 1'b0;
        next_cl_sof     = 1'b0;
        next_cl_eol     = 1'b0;
        if (lk_req_s2 != lk_ack_tgl) begin
            next_lk_ack_tgl = lk_req_s2;
            next_cl_taps    = word.taps;
            next_cl_count   = word.count;
            next_cl_dval    = 1'b1;
            next_cl_sof     = word.sof;
            next_cl_eol     = word.eol;
        end
    end

    always_ff @(posedge link_clk or negedge lrst_q2) begin
        if (!lrst_q2) begin
            lk_req_s1  <= 1'b0;
            lk_req_s2  <= 1'b0;
            lk_ack_tgl <= 1'b0;
            cl_taps    <= '0;
            cl_count   <= 4'h0;
            cl_dval    <= 1'b0;
            cl_sof     <= 1'b0;
            cl_eol     <= 1'b0;
        end else begin
            lk_req_s1  <= req_tgl;
            lk_req_s2  <= lk_req_s1;
            lk_ack_tgl <= next_lk_ack_tgl;
            cl_taps    <= next_cl_taps;
            cl_count   <= next_cl_count;
            cl_dval    <= next_cl_dval;
            cl_sof     <= next_cl_sof;
            cl_eol     <= next_cl_eol;
        end
    end

    // ---------------- Checks ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_q2);

    sequence s_bin_write;
        reg_wr && reg_addr == REG_BIN;
    endsequence

    sequence s_sensor_sum_write;
        s_bin_write ##0 (engine == BFTO_SENSOR && reg_wdata[BIN_VM_BIT]);
    endsequence

    AST_SENSOR_SUM_REFUSED: assert property (s_sensor_sum_write |=> ($stable(sens_cfg) && refused))
        else $error("sensor engine took sum mode");
    AST_SENSOR_FACTOR: assert property (sens_cfg.vf >= 3'h1 && sens_cfg.vf <= 3'h3)
        else $error("sensor factor outside one to three");
    AST_LOGIC_FACTOR: assert property ((s_bin_write ##0 engine == BFTO_LOGIC && reg_wdata[2:0] == 3'h3)
                                       |=> $stable(logic_cfg))
        else $error("logic engine took factor three");
    AST_SENSOR_FOLLOW: assert property (s_bin_write ##0 engine == BFTO_SENSOR
                                        |=> sens_cfg.hf == sens_cfg.vf && sens_cfg.hm == sens_cfg.vm)
        else $error("sensor horizontal setting does not follow vertical");
    AST_ENGINE_KEEP: assert property (s_bin_write ##0 engine == BFTO_SENSOR |=> $stable(logic_cfg))
        else $error("sensor write disturbed logic settings");
    AST_RATE_READBACK: assert property (rate_mhz == (link_rate_select ? RATE1_MHZ : RATE0_MHZ))
        else $error("rate readback disagrees with selected clock");
    AST_WIDTH_CUT: assert property ((out_stb && wsel == BFTO_W8) |-> outv[11:8] == 4'h0)
        else $error("eight bit sample has upper bits set");
    AST_SUM_CLIP: assert property ((out_stb && cfg.hm == BFTO_SUM && vt > 16'h0fff) |-> res == SAMPLE_MAX)
        else $error("sum total not clipped");
    AST_WORD_HOLD: assert property ((req_tgl != $past(req_tgl)) |=> !pix_in_ready [*2])
        else $error("source not held while word crosses");

endmodule // bfto_top

`default_nettype wire

// file: dv/bfto_grabber_model.sv
// Frame grabber model: captures every word sent on the link.
// Assumes cl_* are registered on link_clk by the camera side.
`default_nettype none
module bfto_grabber_model
    import bfto_pkg::*;
(
    input  wire logic                      link_clk,
    input  wire logic [MAX_TAPS-1:0][11:0] cl_taps,
    input  wire logic [3:0]                cl_count,
    input  wire logic                      cl_dval,
    input  wire logic                      cl_sof,
    input  wire logic                      cl_eol,
    output var  logic                      got_v,
    output var  bfto_word_t                got
);
    timeunit 1ns;
    timeprecision 1ns;
    // Sink keeps up at either pixel rate, so it never stalls the camera
    always_ff @(posedge link_clk) begin
        got_v <= cl_dval;
        got   <= '{sof: cl_sof, eol: cl_eol, count: cl_count, taps: cl_taps};
    end
endmodule // bfto_grabber_model
`default_nettype wire

// file: dv/binning_format_tap_output_tb_top.sv
// Bench: register setup, random frames, queued word compare.
// Assumes bfto_pkg and bfto_top are compiled first.
`default_nettype none
module binning_format_tap_output_tb_top import bfto_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, link_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, pix_in_valid = 0;
    logic [7:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0, reg_rdata, rdv;
    logic pix_in_ready, link_rate_select, got_v, cl_dval, cl_sof, cl_eol;
    bfto_pix_t pix_in = '0;
    logic [2:0] sensor_bin_factor;
    bfto_method_t sensor_bin_method;
    logic [MAX_TAPS-1:0][11:0] cl_taps;
    logic [3:0] cl_count;
    bfto_word_t got, ew, mw, exp_q[$];
    logic [11:0] px[4][8];
    // Nibbles: hf, vf, sum, width code, layout code
    logic [19:0] cfgs[4] = '{20'h11020, 20'h21111, 20'h42022, 20'h24123};
    int fails = 0, checks_done = 0;
    initial forever #4 clk = ~clk;
    // Link clock offset so its edges never line up with clk
    initial begin
        #7;
        forever #24 link_clk = ~link_clk;
    end
    bfto_top #(.MAX_LINE(16), .COLOR_SENSOR(1'b0)) u_bfto_top (.clk(clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pix_in_valid(pix_in_valid), .pix_in(pix_in), .pix_in_ready(pix_in_ready),
        .sensor_bin_factor(sensor_bin_factor), .sensor_bin_method(sensor_bin_method),
        .link_rate_select(link_rate_select), .link_clk(link_clk), .cl_taps(cl_taps), .cl_count(cl_count),
        .cl_dval(cl_dval), .cl_sof(cl_sof), .cl_eol(cl_eol));
    bfto_grabber_model u_bfto_grabber_model (.link_clk(link_clk), .cl_taps(cl_taps), .cl_count(cl_count),
        .cl_dval(cl_dval), .cl_sof(cl_sof), .cl_eol(cl_eol), .got_v(got_v), .got(got));
    task automatic check(input logic [127:0] s, input logic [127:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One register access; idle cycle after keeps strobes single-driven
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 rdv = reg_rdata;
        @(posedge clk);
    endtask
    task automatic put(input bfto_pix_t p);
        logic rdy;
        rdy = 1'b0;
        pix_in_valid <= 1'b1;
        pix_in <= p;
        // Ready sampled mid-cycle, so the taking edge is known without a race
        for (int k = 0; k < 500 && rdy !== 1'b1; k++) begin
            @(negedge clk) rdy = pix_in_ready;
            @(posedge clk);
        end
    endtask
    // Expected words are queued before the frame, since words leave mid-line
    task automatic run_cfg(input logic [19:0] c);
        int hf, vf, n, no, tot, v;
        hf = c[19:16];
        vf = c[15:12];
        n = (c[1:0] == 2'h3) ? 10 : 2 << c[1:0];
        acc(1, REG_BIN, {19'h0, c[8], 1'b0, c[18:16], 3'h0, c[8], 1'b0, c[14:12]});
        acc(1, REG_FMT, {30'h0, c[5:4]});
        acc(1, REG_LAYOUT, {30'h0, c[1:0]});
        for (int y = 0; y < 4; y++)
            for (int x = 0; x < 8; x++) px[y][x] = 12'($urandom);
        no = 8 / hf;
        for (int oy = 0; oy < 4 / vf; oy++)
            for (int b = 0; b < no; b += n) begin
                ew = '0;
                ew.sof = (oy == 0 && b == 0);
                ew.eol = (b + n >= no);
                ew.count = 4'((no - b < n) ? no - b : n);
                for (int t = 0; t < ew.count; t++) begin
                    tot = 0;
                    for (int i = 0; i < hf * vf; i++) tot += px[oy * vf + i / hf][(b + t) * hf + i % hf];
                    v = c[8] ? ((tot > 4095) ? 4095 : tot) : tot >> $clog2(hf * vf);
                    ew.taps[t] = 12'(v >> ((c[5:4] == 2'h1) ? 2 : 0));
                end
                exp_q.push_back(ew);
            end
        for (int y = 0; y < 4; y++)
            for (int x = 0; x < 8; x++) put('{sof: x + y == 0, sol: x == 0, eol: x == 7, data: px[y][x]});
        pix_in_valid <= 1'b0;
        for (int k = 0; k < 3000 && exp_q.size() > 0; k++) @(posedge clk);
        check(exp_q.size(), 0);
    endtask
    // Result watcher: oldest note against each captured word
    always @(posedge link_clk) begin
        if (got_v === 1'b1) begin
            mw = 'x;
            if (exp_q.size() > 0) mw = exp_q.pop_front();
            check(got, mw);
        end
    end
    initial begin
        void'($urandom(45881));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        acc(0, REG_RATE_MHZ, 0);
        check(rdv, {24'h0, RATE0_MHZ});
        acc(1, REG_RATE, 1);
        check(link_rate_select, 1'b1);
        acc(0, REG_RATE_MHZ, 0);
        check(rdv, {24'h0, RATE1_MHZ});
        acc(0, 8'h1c, 0);
        check(rdv, 0);
        acc(1, REG_BIN, 32'h0012);
        acc(0, REG_STATUS, 0);
        check(rdv, 32'h2);
        acc(1, REG_BIN, 32'h0103);
        acc(0, REG_BIN, 0);
        check(rdv, 32'h0303);
        acc(1, REG_BIN, 32'h0004);
        check(sensor_bin_factor, 3'h3);
        check(sensor_bin_method, BFTO_AVG);
        acc(1, REG_ENGINE, 1);
        acc(1, REG_BIN, 32'h0303);
        acc(0, REG_STATUS, 0);
        check(rdv, 32'h2);
        acc(1, REG_FMT, 0);
        acc(0, REG_STATUS, 0);
        check(rdv, 32'h2);
        foreach (cfgs[i]) run_cfg(cfgs[i]);
        check(sensor_bin_factor, 3'h3);
        acc(1, REG_ENGINE, 0);
        acc(0, REG_BIN, 0);
        check(rdv, 32'h0303);
        complete_run();
    end
    // Watchdog well past the expected run length
    initial begin
        #400000;
        fails++;
        complete_run();
    end
endmodule // binning_format_tap_output_tb_top
`default_nettype wire
